// >>> logic/capture_compare_channel.sv
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
module capture_compare_channel
    import ccap_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    // counter side
    input wire logic [ccap_pkg::DATA_W-1:0] counter_value_in,
    input wire logic [1:0] count_dir_in,
    input wire logic counter_max_in,
    input wire logic counter_zero_in,
    input wire logic own_match_in,
    input wire logic partner_match_in,
    // pins
    input wire logic capture_input_pin_in,
    output logic timer_wave_output_out,
    // data register to compare logic and capture strobe
    output logic [ccap_pkg::DATA_W-1:0] compare_capture_value_out,
    output logic capture_event_out
);
    import ccap_pkg::*;

    logic [15:0] ctrl_reg;
    logic [DATA_W-1:0] data_reg;
    logic pin_meta_reg, pin_sync_reg, pin_prev_reg;
    logic level_reg, level_next;
    logic sw_rise, sw_fall, pin_rise, pin_fall, rise, fall, trig;
    logic [1:0] src, edge_sel, new_src;
    logic capture_mode, sw_src, period_end;
    logic wr_ctrl;

    assign wr_ctrl = reg_wr_in && (reg_addr_in == ADDR_CTRL);
    assign src = ctrl_reg[CAPSRC_LSB +: 2];
    assign edge_sel = ctrl_reg[CAPEDGE_LSB +: 2];
    assign capture_mode = ctrl_reg[FUNC_BIT];
    assign new_src = reg_wdata_in[CAPSRC_LSB +: 2];
    assign sw_src = (src == SRC_SW_LOW) || (src == SRC_SW_HIGH);

    // software edges come from the write itself, so no sampling delay
    assign sw_rise = wr_ctrl && (src == SRC_SW_LOW) && (new_src == SRC_SW_HIGH);
    assign sw_fall = wr_ctrl && (src == SRC_SW_HIGH) && (new_src == SRC_SW_LOW);
    assign pin_rise = pin_sync_reg && !pin_prev_reg;
    assign pin_fall = !pin_sync_reg && pin_prev_reg;
    assign rise = (src == SRC_PIN) ? pin_rise : (sw_src && sw_rise);
    assign fall = (src == SRC_PIN) ? pin_fall : (sw_src && sw_fall);

    always_comb begin
        case (edge_sel)
            EDGE_RISE: trig = rise;
            EDGE_FALL: trig = fall;
            EDGE_BOTH: trig = rise || fall;
            default: trig = 1'b0;
        endcase
        trig = trig && capture_mode;
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg <= capture_input_pin_in;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= reg_wdata_in & CTRL_WMASK;
        end
    end

    // a capture in the same cycle as a software write wins
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            data_reg <= DATA_RESET;
        end else if (trig) begin
            data_reg <= counter_value_in;
        end else if (reg_wr_in && (reg_addr_in == ADDR_DATA)) begin
            data_reg <= reg_wdata_in[DATA_W-1:0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            capture_event_out <= 1'b0;
        end else begin
            capture_event_out <= trig;
        end
    end

    assign period_end = (count_dir_in == DIR_DOWN) ? counter_zero_in : counter_max_in;

    wave_level u_wave_level (
        .mode_in(ctrl_reg[WMODE_LSB +: 3]),
        .paired_in(ctrl_reg[PAIRED_BIT]),
        .manual_in(ctrl_reg[MANLVL_BIT]),
        .own_match_in(own_match_in),
        .other_match_in(partner_match_in),
        .period_end_in(period_end),
        .level_in(level_reg),
        .level_out(level_next)
    );

    // in capture mode the wave holds its last level
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            level_reg <= 1'b0;
        end else if (!capture_mode) begin
            level_reg <= level_next;
        end
    end

    // polarity is a comparator setting: in capture mode the pin freezes as driven
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            timer_wave_output_out <= 1'b0;
        end else if (!capture_mode) begin
            timer_wave_output_out <= level_next ^ ctrl_reg[POLINV_BIT];
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            compare_capture_value_out <= DATA_RESET;
        end else if (trig) begin
            compare_capture_value_out <= counter_value_in;
        end else if (reg_wr_in && (reg_addr_in == ADDR_DATA)) begin
            compare_capture_value_out <= reg_wdata_in[DATA_W-1:0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            if (reg_addr_in == ADDR_CTRL) begin
                reg_rdata_out <= ctrl_reg;
            end else if (reg_addr_in == ADDR_DATA) begin
                reg_rdata_out <= data_reg;
            end else if (reg_addr_in == ADDR_STAT) begin
                reg_rdata_out <= {14'h0000, pin_sync_reg, level_reg};
            end else begin
                reg_rdata_out <= 16'h0000;
            end
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end
endmodule

// >>> logic/ccap_pkg.sv
package ccap_pkg;
    localparam int CTRL_W = 16;
    localparam int DATA_W = 16;
    // control register field positions
    localparam int CAPSRC_LSB = 10;
    localparam int CAPEDGE_LSB = 8;
    localparam int PAIRED_BIT = 6;
    localparam int MANLVL_BIT = 5;
    localparam int WMODE_LSB = 2;
    localparam int POLINV_BIT = 1;
    localparam int FUNC_BIT = 0;
    localparam logic [15:0] CTRL_WMASK = 16'hff7f;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    // register byte addresses (byte address = 4 * index)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_DATA = 4'h4;
    localparam logic [3:0] ADDR_STAT = 4'h8;
    // capture source codes
    localparam logic [1:0] SRC_PIN = 2'h0;
    localparam logic [1:0] SRC_SW_LOW = 2'h2;
    localparam logic [1:0] SRC_SW_HIGH = 2'h3;
    // capture edge codes
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // wave modes
    localparam logic [2:0] WM_SOFT = 3'h0;
    localparam logic [2:0] WM_SET = 3'h1;
    localparam logic [2:0] WM_TOGRST = 3'h2;
    localparam logic [2:0] WM_SETRST = 3'h3;
    localparam logic [2:0] WM_TOGGLE = 3'h4;
    localparam logic [2:0] WM_RESET = 3'h5;
    localparam logic [2:0] WM_TOGSET = 3'h6;
    localparam logic [2:0] WM_RSTSET = 3'h7;
    // counting directions
    localparam logic [1:0] DIR_UP = 2'h0;
    localparam logic [1:0] DIR_DOWN = 2'h1;
    localparam logic [1:0] DIR_UPDOWN = 2'h2;
endpackage

// >>> logic/wave_level.sv
`timescale 1ns/1ps
// next active/inactive level of the wave, before polarity
module wave_level
    import ccap_pkg::*;
(
    input wire logic [2:0] mode_in,
    input wire logic paired_in,
    input wire logic manual_in,
    input wire logic own_match_in,
    input wire logic other_match_in,
    input wire logic period_end_in,
    input wire logic level_in,
    output logic level_out
);
    always_comb begin
        level_out = level_in;
        if (paired_in) begin
            case (mode_in)
                WM_SOFT: level_out = manual_in;
                WM_SET: if (own_match_in || other_match_in) level_out = 1'b1;
                WM_TOGRST: begin
                    if (other_match_in) level_out = 1'b0;
                    else if (own_match_in) level_out = ~level_in;
                end
                WM_SETRST: begin
                    if (other_match_in) level_out = 1'b0;
                    else if (own_match_in) level_out = 1'b1;
                end
                WM_TOGGLE: if (own_match_in ^ other_match_in) level_out = ~level_in;
                WM_RESET: if (own_match_in || other_match_in) level_out = 1'b0;
                WM_TOGSET: begin
                    if (other_match_in) level_out = 1'b1;
                    else if (own_match_in) level_out = ~level_in;
                end
                default: begin
                    if (other_match_in) level_out = 1'b1;
                    else if (own_match_in) level_out = 1'b0;
                end
            endcase
        end else begin
            case (mode_in)
                WM_SOFT: level_out = manual_in;
                WM_SET: if (own_match_in) level_out = 1'b1;
                WM_TOGRST: begin
                    if (period_end_in) level_out = 1'b0;
                    else if (own_match_in) level_out = ~level_in;
                end
                WM_SETRST: begin
                    if (period_end_in) level_out = 1'b0;
                    else if (own_match_in) level_out = 1'b1;
                end
                WM_TOGGLE: if (own_match_in) level_out = ~level_in;
                WM_RESET: if (own_match_in) level_out = 1'b0;
                WM_TOGSET: begin
                    if (period_end_in) level_out = 1'b1;
                    else if (own_match_in) level_out = ~level_in;
                end
                default: begin
                    if (period_end_in) level_out = 1'b1;
                    else if (own_match_in) level_out = 1'b0;
                end
            endcase
        end
    end
endmodule

// >>> sim/capture_compare_channel_props.sv
`timescale 1ns/1ps
module ccap_checker
    import ccap_pkg::*;
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic [1:0] count_dir_in,
    input wire logic counter_max_in,
    input wire logic counter_zero_in,
    input wire logic own_match_in,
    input wire logic partner_match_in,
    input wire logic timer_wave_output_out,
    input wire logic capture_event_out
);
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (sys_rst_in);
    logic [15:0] c;
    logic wc;
    logic cmp;
    logic per;
    assign wc = reg_wr_in && reg_addr_in == ADDR_CTRL;
    assign cmp = !c[0] && !wc;
    assign per = count_dir_in == DIR_DOWN ? counter_zero_in : counter_max_in;
    // shadow of the control word, so modes are known without looking inside
    always_ff @(posedge clock_in) begin
        if (sys_rst_in)
            c <= 16'h0000;
        else if (wc)
            c <= reg_wdata_in;
    end
    sequence sw_step(logic [1:0] a, logic [1:0] b);
        wc && c[0] && reg_wdata_in[0] && c[11:10] == a && reg_wdata_in[11:10] == b && c[9:8] == reg_wdata_in[9:8];
    endsequence
    sw_rise_a: assert property (sw_step(SRC_SW_LOW, SRC_SW_HIGH) ##0 c[8] |=> capture_event_out)
        else $error("no capture on software rise");
    sw_fall_a: assert property (sw_step(SRC_SW_HIGH, SRC_SW_LOW) ##0 c[9] |=> capture_event_out)
        else $error("no capture on software fall");
    no_capture_a: assert property ((c[9:8] == EDGE_NONE || !c[0]) [*5] |=> !capture_event_out)
        else $error("capture while disabled");
    soft_wave_a: assert property (cmp && c[4:2] == WM_SOFT && !c[1] && $stable(c) |-> timer_wave_output_out == c[5])
        else $error("soft wave level wrong");
    reset_mode_a: assert property (cmp && c[4:2] == WM_RESET && (own_match_in || c[6] && partner_match_in)
        |=> timer_wave_output_out == c[1]) else $error("reset mode not inactive");
    rstset_period_a: assert property (cmp && c[4:2] == WM_RSTSET && !c[6] && per
        |=> timer_wave_output_out == !c[1]) else $error("period did not set wave");
    rstset_pair_a: assert property (cmp && c[4:2] == WM_RSTSET && c[6] && partner_match_in
        |=> timer_wave_output_out == !c[1]) else $error("partner did not set wave");
    togset_match_a: assert property (cmp && c[4:2] == WM_TOGSET && !c[6] && own_match_in && !counter_max_in
        && !counter_zero_in |=> timer_wave_output_out != $past(timer_wave_output_out)) else $error("no toggle");
    capture_hold_a: assert property (c[0] && $past(c[0]) |-> $stable(timer_wave_output_out))
        else $error("wave moved in capture mode");
endmodule
bind capture_compare_channel ccap_checker chk (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .count_dir_in(count_dir_in),
    .counter_max_in(counter_max_in), .counter_zero_in(counter_zero_in), .own_match_in(own_match_in),
    .partner_match_in(partner_match_in), .timer_wave_output_out(timer_wave_output_out),
    .capture_event_out(capture_event_out));

// >>> sim/capture_pin_model.sv
`timescale 1ns/1ps
// far-side pin driver: follows the asked level after a settable lag
module capture_pin_model (
    input wire logic clock_in,
    input wire logic level_in,
    input wire logic [3:0] lag_in,
    output logic pin_out
);
    logic [15:0] hist = 16'h0000;
    always_ff @(posedge clock_in) begin
        hist <= {hist[14:0], level_in};
    end
    assign pin_out = hist[lag_in];
endmodule

// >>> sim/capture_trigger_and_wave_output_bench.sv
`timescale 1ns/1ps
module capture_trigger_and_wave_output_bench;
    import ccap_pkg::*;
    logic clk, rst, wr_s, rd_s, mx, zr, om, pm, lvl, pin, wave;
    logic [3:0] addr, lag;
    logic [15:0] wd, rdata, cnt, ccv;
    logic [1:0] dir;
    int n_errors = 0, total_checks = 0, cyc = 0;
    capture_compare_channel DUT (.clock_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wd),
        .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .counter_value_in(cnt), .count_dir_in(dir),
        .counter_max_in(mx), .counter_zero_in(zr), .own_match_in(om), .partner_match_in(pm),
        .capture_input_pin_in(pin), .timer_wave_output_out(wave), .compare_capture_value_out(ccv),
        .capture_event_out());
    capture_pin_model far_end (.clock_in(clk), .level_in(lvl), .lag_in(lag), .pin_out(pin));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic results();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            results();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    // trailing idle edge keeps a strobe from being set twice in one step
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wd <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk(rdata, exp);
        @(posedge clk);
    endtask
    task automatic wv(input logic exp);
        #1 chk({15'h0000, wave}, {15'h0000, exp});
        @(posedge clk);
    endtask
    // e holds max, zero, own match, partner match
    task automatic ev(input logic [3:0] e, input logic exp);
        {mx, zr, om, pm} <= e;
        @(posedge clk);
        {mx, zr, om, pm} <= 4'h0;
        wv(exp);
    endtask
    function automatic logic [15:0] cw(input logic p, input logic m, input logic [2:0] md, input logic i);
        return {9'h000, p, m, md, i, 1'b0};
    endfunction
    initial begin
        {wr_s, rd_s, mx, zr, om, pm, lvl, addr, lag, wd, cnt, dir} = '0;
        rst = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(ADDR_CTRL, CTRL_RESET);
        rd(ADDR_DATA, DATA_RESET);
        wr(4'hc, 16'hffff);
        rd(4'hc, 16'h0000);
        wr(ADDR_CTRL, 16'hffff);
        rd(ADDR_CTRL, CTRL_WMASK);
        for (int e = 0; e < 4; e++) begin
            wr(ADDR_CTRL, {4'h0, SRC_SW_LOW, e[1:0], 8'h01});
            wr(ADDR_DATA, 16'h0000);
            cnt <= {14'h0400, e[1:0]};
            wr(ADDR_CTRL, {4'h0, SRC_SW_HIGH, e[1:0], 8'h01});
            rd(ADDR_DATA, e[0] ? {14'h0400, e[1:0]} : 16'h0000);
            cnt <= {14'h0800, e[1:0]};
            wr(ADDR_CTRL, {4'h0, SRC_SW_LOW, e[1:0], 8'h01});
            rd(ADDR_DATA, e[1] ? {14'h0800, e[1:0]} : e[0] ? {14'h0400, e[1:0]} : 16'h0000);
        end
        wr(ADDR_DATA, 16'h0000);
        wr(ADDR_CTRL, {4'h0, SRC_SW_LOW, EDGE_BOTH, 8'h00});
        wr(ADDR_CTRL, {4'h0, SRC_SW_HIGH, EDGE_BOTH, 8'h00});
        rd(ADDR_DATA, 16'h0000);
        for (int s = 0; s < 2; s++) begin
            lag <= s ? 4'h9 : 4'h0;
            wr(ADDR_CTRL, {4'h0, SRC_PIN, EDGE_RISE, 8'h01});
            cnt <= s ? 16'h0bcd : 16'h0abc;
            lvl <= 1'b1;
            repeat (16) @(posedge clk);
            cnt <= 16'h0def;
            lvl <= 1'b0;
            repeat (16) @(posedge clk);
            rd(ADDR_DATA, s ? 16'h0bcd : 16'h0abc);
            chk(ccv, s ? 16'h0bcd : 16'h0abc);
        end
        wr(ADDR_CTRL, cw(1'b0, 1'b1, WM_SOFT, 1'b0));
        wv(1'b1);
        rd(ADDR_STAT, 16'h0001);
        wr(ADDR_CTRL, cw(1'b0, 1'b0, WM_SOFT, 1'b0));
        wv(1'b0);
        wr(ADDR_CTRL, cw(1'b0, 1'b0, WM_RSTSET, 1'b0));
        ev(4'h8, 1'b1);
        ev(4'h2, 1'b0);
        dir <= DIR_UPDOWN;
        ev(4'h8, 1'b1);
        dir <= DIR_DOWN;
        ev(4'h2, 1'b0);
        ev(4'h4, 1'b1);
        wr(ADDR_CTRL, cw(1'b0, 1'b0, WM_RSTSET, 1'b1));
        ev(4'h2, 1'b1);
        ev(4'h4, 1'b0);
        dir <= DIR_UP;
        wr(ADDR_CTRL, cw(1'b1, 1'b0, WM_RSTSET, 1'b0));
        ev(4'h2, 1'b0);
        ev(4'h1, 1'b1);
        wr(ADDR_CTRL, cw(1'b0, 1'b0, WM_TOGSET, 1'b0));
        ev(4'h2, 1'b0);
        ev(4'h8, 1'b1);
        ev(4'h2, 1'b0);
        wr(ADDR_CTRL, cw(1'b1, 1'b0, WM_TOGSET, 1'b0));
        ev(4'h1, 1'b1);
        ev(4'h2, 1'b0);
        ev(4'h2, 1'b1);
        wr(ADDR_CTRL, cw(1'b0, 1'b0, WM_RESET, 1'b0));
        ev(4'h8, 1'b1);
        ev(4'h2, 1'b0);
        wr(ADDR_CTRL, cw(1'b0, 1'b0, WM_SET, 1'b0));
        ev(4'h2, 1'b1);
        wr(ADDR_CTRL, cw(1'b0, 1'b0, WM_TOGGLE, 1'b0));
        ev(4'h2, 1'b0);
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_CTRL, cw(1'b1, 1'b0, WM_TOGSET, 1'b0));
            ev(4'h1, 1'b1);
            wr(ADDR_CTRL, cw(1'b1, 1'b0, WM_RESET, 1'b0));
            ev(k ? 4'h2 : 4'h1, 1'b0);
        end
        wr(ADDR_CTRL, cw(1'b0, 1'b1, WM_SOFT, 1'b0) | 16'h0001);
        wv(1'b0);
        ev(4'h8, 1'b0);
        results();
    end
endmodule
